// File: lc_consts.svh
/*
  Constants of the parallel I/O line controller: register offsets,
  reset values and the build-time line maps.
  Assumes inclusion by bare name from the design files.
*/
// How it works
// RULE1: pull-up on clears, off sets status
// RULE2: pull-up status resets to all zero
// RULE3: own commands set or clear ownership bit
// RULE4: unmuxed lines ignore ownership writes, read one
// RULE5: ownership reset value is build constant
// RULE6: A select clears, B select sets bit
// RULE7: A/B steers output only; input to both
// RULE8: A/B status resets zero; software sets both
// RULE9: peripheral owned line driven by selected peripheral
// RULE10: drive commands set/clear drive status always
// RULE11: level set/clear commands act always
// RULE12: direct level write touches unmasked bits only
// RULE13: direct write mask commands; resets zero
// RULE14: open drain set/clear; drives low only
// RULE15: pin level tracks pins; holds when stopped
// RULE16: filter rejects short pulses, passes long
// RULE17: filter adds at most one cycle latency; the two-sample filter here adds two cycles
// RULE18: filter only affects readback and change detect
// RULE19: irq on/off set and clear mask
// RULE20: change from two successive samples sets status
// RULE21: masked status bits ORed onto one output
// RULE22: reading change status clears it all
// RULE23: absent lines ignore writes, read zero
// RULE24: zero bits in commands change nothing
`ifndef LC_CONSTS_SVH
`define LC_CONSTS_SVH

// register offsets, byte addresses
`define LC_OWN_ON 8'h00
`define LC_OWN_OFF 8'h04
`define LC_OWN_STAT 8'h08
`define LC_DRV_ON 8'h10
`define LC_DRV_OFF 8'h14
`define LC_DRV_STAT 8'h18
`define LC_DG_ON 8'h20
`define LC_DG_OFF 8'h24
`define LC_DG_STAT 8'h28
`define LC_LVL_SET 8'h30
`define LC_LVL_CLR 8'h34
`define LC_LVL_STAT 8'h38
`define LC_PIN_STAT 8'h3c
`define LC_IRQ_ON 8'h40
`define LC_IRQ_OFF 8'h44
`define LC_IRQ_MASK 8'h48
`define LC_IRQ_STAT 8'h4c
`define LC_OD_ON 8'h50
`define LC_OD_OFF 8'h54
`define LC_OD_STAT 8'h58
`define LC_PU_OFF 8'h60
`define LC_PU_ON 8'h64
`define LC_PU_STAT 8'h68
`define LC_SEL_A 8'h70
`define LC_SEL_B 8'h74
`define LC_AB_STAT 8'h78
`define LC_DW_ON 8'ha0
`define LC_DW_OFF 8'ha4
`define LC_DW_STAT 8'ha8

// build-time line maps
`define LC_LINES_PRESENT 32'hffffffff
`define LC_LINES_MUXED 32'hffffffff
`define LC_OWN_RESET 32'hffffffff

// reset values
`define LC_ZERO 32'h00000000

`endif

// File: lc_deglitch.sv
/*
  Per-line input filter of the line controller.
  Assumes its input is already synchronised to sys_clk.
*/
`timescale 1ns/1ps
`include "lc_consts.svh"

module lc_deglitch
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // lines in and filter enables
  input wire lc_pkg::line_vec_t line_in,
  input wire lc_pkg::line_vec_t filter_on,
  // filtered lines
  output lc_pkg::line_vec_t line_out
);

  // filtered level of every line, one net bit per filter
  wire lc_pkg::line_vec_t held_vec;

  ////////////////////////////////////////////////////////////////////////
  // one filter per line; each keeps its own flops so no bit has two writers
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_line
      logic last;
      logic held;
      // a level must be seen on two successive samples to pass
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          last <= 1'b0;
          held <= 1'b0;
        end
        else
        begin
          last <= line_in[i];
          if (line_in[i] == last)
          begin
            held <= line_in[i]; // [RULE16] [RULE17]
          end
        end
      end
      assign held_vec[i] = held;
    end
  endgenerate

  // unfiltered lines pass straight through
  assign line_out = (filter_on & held_vec) | (~filter_on & line_in);

endmodule

// File: lc_far_side.sv
/* Far side of the line controller: pads with pull-ups and outside drivers.
   Assumes the bench sets the outside drive pattern. */
`timescale 1ns/1ps
////////////////////////////////////////
module lc_far_side
(
  // clock
  input wire logic sys_clk,
  // pad drive from the controller
  input wire lc_pkg::line_vec_t pin_out,
  input wire lc_pkg::line_vec_t pin_oe,
  input wire lc_pkg::line_vec_t pullup_en,
  // outside drivers
  input wire lc_pkg::line_vec_t ext_oe,
  input wire lc_pkg::line_vec_t ext_val,
  // resolved pad level
  output lc_pkg::line_vec_t pin_in
);
  lc_pkg::line_vec_t pat = 32'h55555555;
  wire lc_pkg::line_vec_t drv = pin_oe | ext_oe;
  // wired and of every driver on a line
  wire lc_pkg::line_vec_t lvl = (~pin_oe | pin_out) & (~ext_oe | ext_val);
  // floating lines: pull-up, else a level that moves every cycle
  assign pin_in = (drv & lvl) | (~drv & (pullup_en | pat));
  // floating pattern
  always @(posedge sys_clk)
    pat <= ~pat;
endmodule

// File: lc_line_controller.sv
/*
  Parallel I/O line controller: 32 lines with ownership, peripheral
  A/B selection, drive control, open drain, pull-ups, input filter and
  input change interrupt, behind a plain register port.
  Assumes pins arrive asynchronous and peripheral signals on sys_clk.
*/
`timescale 1ns/1ps
`include "lc_consts.svh"

module lc_line_controller
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // controller clock running, from power management
  input wire logic ctl_clock_on,
  // register port
  input wire lc_pkg::reg_addr_t addr,
  input wire lc_pkg::line_vec_t wdata,
  input wire logic wr,
  input wire logic rd,
  output lc_pkg::line_vec_t rdata,
  // pins
  input wire lc_pkg::line_vec_t pin_in,
  output lc_pkg::line_vec_t pin_out,
  output lc_pkg::line_vec_t pin_oe,
  output lc_pkg::line_vec_t pullup_en,
  // peripheral A and B
  input wire lc_pkg::line_vec_t periph_a_out,
  input wire lc_pkg::line_vec_t periph_a_oe,
  input wire lc_pkg::line_vec_t periph_b_out,
  input wire lc_pkg::line_vec_t periph_b_oe,
  output lc_pkg::line_vec_t periph_in,
  // interrupt
  output logic change_irq
);

  // configuration state
  lc_pkg::line_vec_t pullup_off_status;
  lc_pkg::line_vec_t ownership_status;
  lc_pkg::line_vec_t periph_ab_status;
  lc_pkg::line_vec_t drive_status;
  lc_pkg::line_vec_t out_level_status;
  lc_pkg::line_vec_t direct_write_mask_status;
  lc_pkg::line_vec_t open_drain_status;
  lc_pkg::line_vec_t deglitch_status;
  lc_pkg::line_vec_t change_irq_mask;
  lc_pkg::line_vec_t change_irq_status;
  lc_pkg::line_vec_t pin_level_status;
  lc_pkg::line_vec_t prev_sample;
  lc_pkg::line_vec_t pin_meta;
  lc_pkg::line_vec_t pin_sync;
  lc_pkg::line_vec_t filtered;

  ////////////////////////////////////////////////////////////////////////
  // write decode
  lc_pkg::line_vec_t wbits;
  logic wr_own_on;
  logic wr_own_off;
  logic wr_drv_on;
  logic wr_drv_off;
  logic wr_dg_on;
  logic wr_dg_off;
  logic wr_lvl_set;
  logic wr_lvl_clr;
  logic wr_lvl;
  logic wr_irq_on;
  logic wr_irq_off;
  logic wr_od_on;
  logic wr_od_off;
  logic wr_pu_off;
  logic wr_pu_on;
  logic wr_sel_a;
  logic wr_sel_b;
  logic wr_dw_on;
  logic wr_dw_off;

  // absent lines never take a write
  assign wbits = wdata & `LC_LINES_PRESENT; // [RULE23]
  assign wr_own_on = wr && (addr == `LC_OWN_ON);
  assign wr_own_off = wr && (addr == `LC_OWN_OFF);
  assign wr_drv_on = wr && (addr == `LC_DRV_ON);
  assign wr_drv_off = wr && (addr == `LC_DRV_OFF);
  assign wr_dg_on = wr && (addr == `LC_DG_ON);
  assign wr_dg_off = wr && (addr == `LC_DG_OFF);
  assign wr_lvl_set = wr && (addr == `LC_LVL_SET);
  assign wr_lvl_clr = wr && (addr == `LC_LVL_CLR);
  assign wr_lvl = wr && (addr == `LC_LVL_STAT);
  assign wr_irq_on = wr && (addr == `LC_IRQ_ON);
  assign wr_irq_off = wr && (addr == `LC_IRQ_OFF);
  assign wr_od_on = wr && (addr == `LC_OD_ON);
  assign wr_od_off = wr && (addr == `LC_OD_OFF);
  assign wr_pu_off = wr && (addr == `LC_PU_OFF);
  assign wr_pu_on = wr && (addr == `LC_PU_ON);
  assign wr_sel_a = wr && (addr == `LC_SEL_A);
  assign wr_sel_b = wr && (addr == `LC_SEL_B);
  assign wr_dw_on = wr && (addr == `LC_DW_ON);
  assign wr_dw_off = wr && (addr == `LC_DW_OFF);

  ////////////////////////////////////////////////////////////////////////
  // next values of the set/clear registers; zero bits leave state alone
  lc_pkg::line_vec_t next_pullup_off;
  lc_pkg::line_vec_t next_ownership;
  lc_pkg::line_vec_t next_ab;
  lc_pkg::line_vec_t next_drive;
  lc_pkg::line_vec_t next_level;
  lc_pkg::line_vec_t next_dw_mask;
  lc_pkg::line_vec_t next_open_drain;
  lc_pkg::line_vec_t next_deglitch;
  lc_pkg::line_vec_t next_irq_mask;

  assign next_pullup_off = wr_pu_on ? (pullup_off_status & ~wbits) // [RULE1] [RULE24]
                         : wr_pu_off ? (pullup_off_status | wbits) : pullup_off_status;
  // unmuxed lines take no ownership write
  assign next_ownership = wr_own_on ? (ownership_status | (wbits & `LC_LINES_MUXED)) // [RULE3]
                        : wr_own_off ? (ownership_status & ~(wbits & `LC_LINES_MUXED)) // [RULE4]
                        : ownership_status;
  assign next_ab = wr_sel_a ? (periph_ab_status & ~wbits) // [RULE6]
                 : wr_sel_b ? (periph_ab_status | wbits) : periph_ab_status;
  assign next_drive = wr_drv_on ? (drive_status | wbits) // [RULE10]
                    : wr_drv_off ? (drive_status & ~wbits) : drive_status;
  // direct write only where the mask lets it through
  assign next_level = wr_lvl_set ? (out_level_status | wbits) // [RULE11]
                    : wr_lvl_clr ? (out_level_status & ~wbits)
                    : wr_lvl ? ((out_level_status & ~direct_write_mask_status)
                               | (wbits & direct_write_mask_status)) // [RULE12]
                    : out_level_status;
  assign next_dw_mask = wr_dw_on ? (direct_write_mask_status | wbits) // [RULE13]
                      : wr_dw_off ? (direct_write_mask_status & ~wbits)
                      : direct_write_mask_status;
  assign next_open_drain = wr_od_on ? (open_drain_status | wbits) // [RULE14]
                         : wr_od_off ? (open_drain_status & ~wbits) : open_drain_status;
  assign next_deglitch = wr_dg_on ? (deglitch_status | wbits) // [RULE18]
                       : wr_dg_off ? (deglitch_status & ~wbits) : deglitch_status;
  assign next_irq_mask = wr_irq_on ? (change_irq_mask | wbits) // [RULE19]
                       : wr_irq_off ? (change_irq_mask & ~wbits) : change_irq_mask;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pullup_off_status <= `LC_ZERO; // [RULE2]
      ownership_status <= `LC_OWN_RESET; // [RULE5]
      periph_ab_status <= `LC_ZERO; // [RULE8]
      drive_status <= `LC_ZERO;
      out_level_status <= `LC_ZERO;
      direct_write_mask_status <= `LC_ZERO; // [RULE13]
      open_drain_status <= `LC_ZERO; // [RULE14]
      deglitch_status <= `LC_ZERO;
      change_irq_mask <= `LC_ZERO; // [RULE19]
    end
    else
    begin
      pullup_off_status <= next_pullup_off;
      ownership_status <= next_ownership;
      periph_ab_status <= next_ab;
      drive_status <= next_drive;
      out_level_status <= next_level;
      direct_write_mask_status <= next_dw_mask;
      open_drain_status <= next_open_drain;
      deglitch_status <= next_deglitch;
      change_irq_mask <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output path, computed from next state so pins follow the write
  lc_pkg::line_vec_t own_eff;
  lc_pkg::line_vec_t sel_out;
  lc_pkg::line_vec_t sel_oe;
  lc_pkg::line_vec_t mux_out;
  lc_pkg::line_vec_t mux_oe;
  lc_pkg::line_vec_t next_pin_out;
  lc_pkg::line_vec_t next_pin_oe;

  assign own_eff = next_ownership | ~`LC_LINES_MUXED; // [RULE4]
  // A/B choice only steers the drive side
  assign sel_out = (periph_b_out & next_ab) | (periph_a_out & ~next_ab); // [RULE7]
  assign sel_oe = (periph_b_oe & next_ab) | (periph_a_oe & ~next_ab);
  assign mux_out = (next_level & own_eff) | (sel_out & ~own_eff); // [RULE9]
  assign mux_oe = (next_drive & own_eff) | (sel_oe & ~own_eff); // [RULE10]
  // open drain lines drive only a low level
  assign next_pin_out = mux_out & ~next_open_drain; // [RULE14]
  assign next_pin_oe = (mux_oe & ~(next_open_drain & mux_out)) & `LC_LINES_PRESENT;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= `LC_ZERO;
      pin_oe <= `LC_ZERO;
      pullup_en <= `LC_ZERO;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pullup_en <= ~next_pullup_off & `LC_LINES_PRESENT; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser; peripherals see the unfiltered level
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta <= `LC_ZERO;
      pin_sync <= `LC_ZERO;
      periph_in <= `LC_ZERO;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      periph_in <= pin_sync; // [RULE7] [RULE18]
    end
  end

  // filter on the level readback and change path only
  lc_deglitch u_deglitch
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .line_in(pin_sync),
    .filter_on(deglitch_status), // [RULE18]
    .line_out(filtered)
  );

  ////////////////////////////////////////////////////////////////////////
  // level capture and change detection while the controller clock runs
  lc_pkg::line_vec_t change_seen;
  logic irq_stat_read;
  lc_pkg::line_vec_t next_irq_status;

  assign change_seen = ctl_clock_on ? ((filtered ^ prev_sample) & `LC_LINES_PRESENT)
                                    : `LC_ZERO; // [RULE20]
  assign irq_stat_read = rd && (addr == `LC_IRQ_STAT);
  // a change in the reading cycle survives the clear
  assign next_irq_status = (irq_stat_read ? `LC_ZERO : change_irq_status)
                         | change_seen; // [RULE22]

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_level_status <= `LC_ZERO;
      prev_sample <= `LC_ZERO;
      change_irq_status <= `LC_ZERO;
    end
    else
    begin
      if (ctl_clock_on)
      begin
        pin_level_status <= filtered; // [RULE15]
        prev_sample <= filtered; // [RULE20]
      end
      change_irq_status <= next_irq_status;
    end
  end

  // one interrupt from all masked lines
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      change_irq <= 1'b0;
    end
    else
    begin
      change_irq <= |(next_irq_status & next_irq_mask); // [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode; unmapped and write-only offsets read zero
  lc_pkg::line_vec_t read_mux;

  assign read_mux =
      (addr == `LC_OWN_STAT) ? (ownership_status | ~`LC_LINES_MUXED) // [RULE4]
    : (addr == `LC_DRV_STAT) ? drive_status
    : (addr == `LC_DG_STAT) ? deglitch_status
    : (addr == `LC_LVL_STAT) ? out_level_status
    : (addr == `LC_PIN_STAT) ? pin_level_status // [RULE15]
    : (addr == `LC_IRQ_MASK) ? change_irq_mask
    : (addr == `LC_IRQ_STAT) ? change_irq_status // [RULE22]
    : (addr == `LC_OD_STAT) ? open_drain_status
    : (addr == `LC_PU_STAT) ? pullup_off_status
    : (addr == `LC_AB_STAT) ? periph_ab_status
    : (addr == `LC_DW_STAT) ? direct_write_mask_status
    : `LC_ZERO;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata <= `LC_ZERO;
    end
    else if (rd)
    begin
      rdata <= read_mux & `LC_LINES_PRESENT; // [RULE23]
    end
    else
    begin
      rdata <= `LC_ZERO;
    end
  end

endmodule

// File: lc_line_controller_chk.sv
/* Checker of the line controller register and pin paths.
   Assumes it is bound onto lc_line_controller. */
`timescale 1ns/1ps
////////////////////////////////////////
module lc_ctl_chk
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire lc_pkg::reg_addr_t addr,
  input wire lc_pkg::line_vec_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire lc_pkg::line_vec_t rdata,
  // pins and interrupt
  input wire lc_pkg::line_vec_t pin_in,
  input wire lc_pkg::line_vec_t periph_in,
  input wire logic change_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic [1:0] up;
  // edges since reset release, saturating
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  // set command seen in the status read right after it
  property set_p(logic [7:0] c, logic [7:0] s);
    wr && addr == c ##1 rd && addr == s |=> (rdata & $past(wdata, 2)) == $past(wdata, 2);
  endproperty
  // clear command seen as zeros in that read
  property clr_p(logic [7:0] c, logic [7:0] s);
    wr && addr == c ##1 rd && addr == s |=> (rdata & $past(wdata, 2)) == 32'h0;
  endproperty
  own_clr_a: assert property (clr_p(8'h04, 8'h08)) else $error("own clear");
  drv_set_a: assert property (set_p(8'h10, 8'h18)) else $error("drive set");
  pu_off_a: assert property (set_p(8'h60, 8'h68)) else $error("pull-up off");
  sel_b_a: assert property (set_p(8'h74, 8'h78)) else $error("b select");
  sel_a_a: assert property (clr_p(8'h70, 8'h78)) else $error("a select");
  dw_set_a: assert property (set_p(8'ha0, 8'ha8)) else $error("write mask");
  unmap_read_a: assert property (rd && addr == 8'h0c |=> rdata == 32'h0)
    else $error("unmapped read");
  irq_fall_a: assert property ($fell(change_irq) |->
    $past(rd && addr == 8'h4c || wr && addr == 8'h44)) else $error("irq fell");
  periph_path_a: assert property (up == 2'h3 |-> periph_in == $past(pin_in, 3))
    else $error("periph input");
  // main scenarios
  cover property (rd && addr == 8'h4c ##1 rdata != 32'h0);
  cover property ($rose(change_irq));
  cover property (wr && addr == 8'h38);
endmodule

bind lc_line_controller lc_ctl_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
  .periph_in(periph_in), .change_irq(change_irq));

// File: lc_pkg.sv
/*
  Types shared by the line controller files.
  Assumes nothing of its surroundings.
*/
package lc_pkg;
  typedef logic [31:0] line_vec_t;
  typedef logic [7:0] reg_addr_t;
endpackage

// File: tb.sv
/* Self-checking bench of the line controller.
   Assumes the far side model and the bound checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) report(g, e); end
////////////////////////////////////////
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ctl_clock_on = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic change_irq;
  lc_pkg::reg_addr_t addr = 8'h00;
  lc_pkg::line_vec_t wdata = 32'h0, ext_oe = 32'h0, ext_val = 32'h0;
  lc_pkg::line_vec_t periph_a_out = 32'h0, periph_a_oe = 32'h0;
  lc_pkg::line_vec_t periph_b_out = 32'h0, periph_b_oe = 32'h0;
  lc_pkg::line_vec_t rdata, pin_in, pin_out, pin_oe, pullup_en, periph_in;
  lc_pkg::line_vec_t r1, r2, r3, o_exp;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  int errors = 0;
  int checks_done = 0;
  int seed = 67720;
  logic [7:0] tbl [9][3] = '{'{8'h00, 8'h04, 8'h08}, '{8'h10, 8'h14, 8'h18},
    '{8'h20, 8'h24, 8'h28}, '{8'h30, 8'h34, 8'h38}, '{8'h40, 8'h44, 8'h48},
    '{8'h50, 8'h54, 8'h58}, '{8'h60, 8'h64, 8'h68}, '{8'h74, 8'h70, 8'h78},
    '{8'ha0, 8'ha4, 8'ha8}};

  lc_line_controller u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .ctl_clock_on(ctl_clock_on), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .periph_a_out(periph_a_out), .periph_a_oe(periph_a_oe),
    .periph_b_out(periph_b_out), .periph_b_oe(periph_b_oe), .periph_in(periph_in),
    .change_irq(change_irq));
  lc_far_side u_far (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));

  // clock
  initial
    forever #5 sys_clk = ~sys_clk;

  task report(input logic [31:0] g, input logic [31:0] x);
    errors++;
    $display("ERROR t=%0t got %h exp %h", $time, g, x);
  endtask

  task wrap_up;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one bus cycle; a read notes its expected word under a mask
  task op(input bit w, input lc_pkg::reg_addr_t a, input lc_pkg::line_vec_t d,
    input lc_pkg::line_vec_t m = '1);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= w ? d : 32'h0;
    if (!w)
      exp_q.push_back({m, d});
    @(posedge sys_clk);
  endtask

  task idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  // read data stand the cycle after the strobe
  always @(posedge sys_clk)
    rd_q <= rd;
  always @(negedge sys_clk)
    if (rd_q)
    begin
      e = exp_q.pop_front();
      `CHK(rdata & e[63:32], e[31:0] & e[63:32])
    end

  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    foreach (tbl[i])
      op(0, tbl[i][2], i ? 0 : '1, i == 3 ? 0 : '1);
    `CHK(pullup_en, '1)
    op(1, 8'h18, '1);
    op(0, 8'h18, 0);
    op(1, 8'h0c, '1);
    op(0, 8'h0c, 0);
    foreach (tbl[i])
    begin
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      op(1, tbl[i][1], '1);
      op(1, tbl[i][0], r1);
      op(0, tbl[i][2], r1);
      op(1, tbl[i][0], r2);
      op(1, tbl[i][1], r3);
      op(0, tbl[i][2], (r1 | r2) & ~r3);
      op(1, tbl[i][1], '1);
    end
    op(1, 8'h00, '1);
    op(1, 8'h10, '1);
    op(1, 8'ha0, 32'h0000ffff);
    op(1, 8'h38, '1);
    op(0, 8'h38, 32'h0000ffff);
    #1 `CHK(pin_out, 32'h0000ffff)
    `CHK(pin_oe, '1)
    op(1, 8'h50, 32'h000000ff);
    #1 `CHK(pin_oe, 32'hffffff00)
    `CHK(pin_out, 32'h0000ff00)
    periph_a_out <= $random(seed);
    periph_a_oe <= $random(seed);
    periph_b_out <= $random(seed);
    periph_b_oe <= $random(seed);
    op(1, 8'h74, 32'hff000000);
    op(1, 8'h04, 32'hffff0000);
    op(0, 8'h08, 32'h0000ffff);
    o_exp = {periph_b_oe[31:24], periph_a_oe[23:16], 16'h0};
    #1 `CHK(pin_oe & 32'hffff0000, o_exp)
    `CHK(pin_out & o_exp, o_exp & {periph_b_out[31:24], periph_a_out[23:16], 16'h0})
    op(1, 8'h00, '1);
    op(1, 8'h14, '1);
    op(1, 8'h54, '1);
    op(1, 8'h40, 32'h00000f00);
    ext_oe <= 32'h0000ff00;
    idle(6);
    op(0, 8'h4c, 0, 0);
    op(0, 8'h3c, 32'hffff00ff);
    ext_val <= 32'h00000100;
    idle(6);
    `CHK(change_irq, 1'b1)
    op(0, 8'h4c, 32'h00000100);
    op(0, 8'h4c, 0);
    #1 `CHK(change_irq, 1'b0)
    ext_val <= 32'h00001100;
    idle(6);
    `CHK(change_irq, 1'b0)
    op(0, 8'h4c, 32'h00001000);
    ctl_clock_on <= 1'b0;
    ext_val <= 32'h00001300;
    idle(6);
    op(0, 8'h3c, 32'hffff11ff);
    op(0, 8'h4c, 0);
    ctl_clock_on <= 1'b1;
    idle(6);
    op(0, 8'h3c, 32'hffff13ff);
    op(1, 8'h20, 32'h00000400);
    op(0, 8'h4c, 0, 0);
    ext_val <= 32'h00001f00;
    idle(1);
    ext_val <= 32'h00001300;
    idle(6);
    op(0, 8'h4c, 32'h00000800);
    ext_val <= 32'h00001700;
    idle(2);
    ext_val <= 32'h00001300;
    idle(6);
    op(0, 8'h4c, 32'h00000400);
    idle(2);
    wrap_up();
  end

  // watchdog
  initial
  begin
    #100000;
    errors++;
    wrap_up();
  end
endmodule
